/* File: chrp_defines.svh */
`ifndef CHRP_DEFINES_SVH
`define CHRP_DEFINES_SVH

// ----------------------------------------
// csr addresses
// ----------------------------------------
`define CHRP_CSR_PAUSE_ADDR   12'h7C2
`define CHRP_CSR_PMC_ADDR     12'h7C6

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CHRP_PMC_HALT_BIT     0
`define CHRP_PAUSE_RESET      32'h0000_0000
`define CHRP_CSR_READ_ZERO    32'h0000_0000

// ----------------------------------------
// timing
// ----------------------------------------
`define CHRP_PAUSE_DEC        32'h0000_0001

`endif

/* File: chrp_pkg.sv */
package chrp_pkg;

	typedef enum logic [1:0]
	{
		CHRP_RUNNING,
		CHRP_QUIESCE,
		CHRP_POWER_HALTED,
		CHRP_DEBUG_HALTED
	} chrp_state_t;

	// csr access from the core's csr pipe
	typedef struct packed
	{
		logic        wr_en;
		logic        rd_en;
		logic [11:0] addr;
		logic [31:0] wdata;
	} chrp_csr_req_t;

	// wake-up sources while in power halt
	typedef struct packed
	{
		logic pmu_run;
		logic pic_wakeup;
		logic ext_timer;
		logic int_timer;
		logic nmi;
	} chrp_wake_t;

endpackage

/* File: chrp_pause_counter.sv */
`timescale 1ns/1ps
`include "chrp_defines.svh"

module chrp_pause_counter
(
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        load,
	input  wire logic [31:0] load_value,
	input  wire logic        freeze,
	input  wire logic        abort,
	output logic             pausing
);

	logic [31:0] count_r;
	logic [31:0] count_nxt;

	// ----------------------------------------
	// countdown
	// ----------------------------------------
	always_comb
	begin
		count_nxt = count_r;
		if (load)
			count_nxt = load_value;
		else if (abort)
			count_nxt = `CHRP_PAUSE_RESET;
		else if (!freeze && count_r != `CHRP_PAUSE_RESET)
			count_nxt = count_r - `CHRP_PAUSE_DEC;
	end

	// freeze holds the count while not running; load and abort override it
	always_ff @(posedge core_clk)
	begin
		if (srst)
			count_r <= `CHRP_PAUSE_RESET;
		else
			count_r <= count_nxt;
	end

	assign pausing = (count_r != `CHRP_PAUSE_RESET);

endmodule

/* File: chrp_halt_ctrl.sv */
// Notes on behaviour
// - ack multi-core halt even when already debug-halted
// - multi-core run waits for debugger operation end; the code waits only if the debugger also holds a halt
// - debugger resume waits for pending multi-core run
// - all halts released: run, drop debug status
// - run ack only once actually running
// - both sources must issue run to leave
// - power halt wakes on five wake sources
// - low-priority external interrupts ignored while halted
// - wakeup interrupt needs global and external enables
// - pending interrupts serviced once running again
// - halt bit write starts quiesce, then halted
// - halt bit write ignored in debug mode
// - halt bit reads zero, upper bits zero
// - reserved bits zero, writes any value legal
// - dma keeps being served while halted
// - pause csr write stops execution, counts down
// - pause csr reads zero, resets zero
// - pause keeps running state, stays interruptible
// - internal timer interrupt ends a pause
// - power halt during pause freezes the count
// - pause length need not be cycle exact
// - wait-for-interrupt executes as no-operation
// - run ack drops after run request drops
`timescale 1ns/1ps
`include "chrp_defines.svh"

module chrp_halt_ctrl
(
	input  wire logic                   core_clk,
	input  wire logic                   srst,
	// csr port
	input  wire chrp_pkg::chrp_csr_req_t csr_req,
	output logic [31:0]                 csr_rdata,
	output logic                        csr_hit,
	// core debugger
	input  wire logic                   dbg_halt_req,
	input  wire logic                   dbg_resume_req,
	input  wire logic                   dbg_op_busy,
	// multi-core debug controller
	input  wire logic                   mpc_halt_req,
	output logic                        mpc_halt_ack,
	input  wire logic                   mpc_run_req,
	output logic                        mpc_run_ack,
	input  wire logic                   mpc_reset_run,
	output logic                        debug_mode_status,
	// power management unit
	input  wire logic                   pmu_halt_req,
	input  wire logic                   pmu_run_req,
	output logic                        pmu_halted,
	// wake and interrupt sources
	input  wire chrp_pkg::chrp_wake_t   wake,
	input  wire logic                   ext_int_pending,
	input  wire logic                   mstatus_mie,
	input  wire logic                   mie_meie,
	input  wire logic                   any_int,
	// pipeline side
	input  wire logic                   pipe_idle,
	input  wire logic                   wfi_exec,
	input  wire logic                   dma_req,
	output logic                        dma_grant,
	output logic                        exec_stall,
	output logic                        int_take_ok,
	output logic                        wfi_retire,
	output logic                        core_running
);

	chrp_pkg::chrp_state_t state_r;
	chrp_pkg::chrp_state_t state_nxt;

	logic dbg_hold_r;
	logic mpc_hold_r;
	logic run_ack_r;
	logic halt_ack_r;
	logic started_r;
	logic pause_active;
	logic wake_any;
	logic fw_halt_wr;
	logic pause_wr;
	logic pause_abort;
	logic [31:0] rdata_r;
	logic hit_r;

	// ----------------------------------------
	// csr decode
	// ----------------------------------------
	function automatic logic csr_match
	(
		input chrp_pkg::chrp_csr_req_t req,
		input logic [11:0]             addr
	);
		csr_match = (req.addr == addr);
	endfunction

	// either debug source asking for a halt
	function automatic logic halt_requested
	(
		input logic dbg_req,
		input logic mpc_req
	);
		halt_requested = dbg_req || mpc_req;
	endfunction

	// write of one to the halt bit, dropped in debug mode
	assign fw_halt_wr = csr_req.wr_en
		&& csr_match(csr_req, `CHRP_CSR_PMC_ADDR)
		&& csr_req.wdata[`CHRP_PMC_HALT_BIT]
		&& state_r != chrp_pkg::CHRP_DEBUG_HALTED;

	assign pause_wr = csr_req.wr_en
		&& csr_match(csr_req, `CHRP_CSR_PAUSE_ADDR)
		&& state_r == chrp_pkg::CHRP_RUNNING;

	// ----------------------------------------
	// wake-up qualification
	// ----------------------------------------
	// only the highest-priority level reaches here as pic_wakeup;
	// lower levels are simply not looked at while halted
	always_comb
	begin
		wake_any = wake.pmu_run
			|| (wake.pic_wakeup && mstatus_mie && mie_meie)
			|| wake.ext_timer
			|| wake.int_timer
			|| wake.nmi;
	end

	// ----------------------------------------
	// halt source tracking
	// ----------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (srst)
			dbg_hold_r <= 1'b0;
		else if (dbg_halt_req)
			dbg_hold_r <= 1'b1;
		else if (dbg_resume_req && !dbg_op_busy)
			dbg_hold_r <= 1'b0;
	end

	// reset strap taken on the first clock after release
	always_ff @(posedge core_clk)
	begin
		if (srst)
			started_r <= 1'b0;
		else
			started_r <= 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			mpc_hold_r <= 1'b0;
		else if (!started_r && !mpc_reset_run)
			mpc_hold_r <= 1'b1;
		else if (mpc_halt_req)
			mpc_hold_r <= 1'b1;
		else if (mpc_run_req)
			mpc_hold_r <= 1'b0;
	end

	// ----------------------------------------
	// activity state
	// ----------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			chrp_pkg::CHRP_RUNNING:
			begin
				if (halt_requested(dbg_halt_req, mpc_halt_req) || (!started_r && !mpc_reset_run))
					state_nxt = chrp_pkg::CHRP_DEBUG_HALTED;
				else if (fw_halt_wr || pmu_halt_req)
					state_nxt = chrp_pkg::CHRP_QUIESCE;
			end
			chrp_pkg::CHRP_QUIESCE:
			begin
				if (halt_requested(dbg_halt_req, mpc_halt_req))
					state_nxt = chrp_pkg::CHRP_DEBUG_HALTED;
				else if (pipe_idle)
					state_nxt = chrp_pkg::CHRP_POWER_HALTED;
			end
			chrp_pkg::CHRP_POWER_HALTED:
			begin
				if (halt_requested(dbg_halt_req, mpc_halt_req))
					state_nxt = chrp_pkg::CHRP_DEBUG_HALTED;
				else if (wake_any || pmu_run_req)
					state_nxt = chrp_pkg::CHRP_RUNNING;
			end
			chrp_pkg::CHRP_DEBUG_HALTED:
			begin
				// both holds must be gone, whichever cleared last
				if (!dbg_hold_r && !mpc_hold_r && !dbg_halt_req && !mpc_halt_req)
					state_nxt = chrp_pkg::CHRP_RUNNING;
			end
			default:
				state_nxt = chrp_pkg::CHRP_RUNNING;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			state_r <= chrp_pkg::CHRP_RUNNING;
		else
			state_r <= state_nxt;
	end

	// ----------------------------------------
	// multi-core handshakes
	// ----------------------------------------
	// halt ack also given when already debug halted, no state change
	always_ff @(posedge core_clk)
	begin
		if (srst)
			halt_ack_r <= 1'b0;
		else
			halt_ack_r <= mpc_halt_req && state_r == chrp_pkg::CHRP_DEBUG_HALTED;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			run_ack_r <= 1'b0;
		else if (!mpc_run_req)
			run_ack_r <= 1'b0;
		else if (state_r == chrp_pkg::CHRP_RUNNING && !pmu_halt_req)
			run_ack_r <= 1'b1;
	end

	// ----------------------------------------
	// status outputs
	// ----------------------------------------
	assign mpc_halt_ack      = halt_ack_r;
	assign mpc_run_ack       = run_ack_r;
	assign debug_mode_status = (state_r == chrp_pkg::CHRP_DEBUG_HALTED);
	assign pmu_halted        = (state_r == chrp_pkg::CHRP_POWER_HALTED);
	assign core_running      = (state_r == chrp_pkg::CHRP_RUNNING);

	// ----------------------------------------
	// pause
	// ----------------------------------------
	// stall is taken a cycle late; pause length is approximate
	assign pause_abort = any_int || wake.int_timer;

	chrp_pause_counter u_pause
	(
		.core_clk   (core_clk),
		.srst       (srst),
		.load       (pause_wr),
		.load_value (csr_req.wdata),
		.freeze     (state_r != chrp_pkg::CHRP_RUNNING),
		.abort      (pause_abort),
		.pausing    (pause_active)
	);

	// pause stalls execution only; state stays running
	assign exec_stall = pause_active || (state_r != chrp_pkg::CHRP_RUNNING);

	// interrupts are only taken in running, pending ones then fire
	assign int_take_ok = (state_r == chrp_pkg::CHRP_RUNNING) && ext_int_pending;

	// dma arbitration does not care about halt state
	assign dma_grant  = dma_req;
	assign wfi_retire = wfi_exec;

	// ----------------------------------------
	// csr read
	// ----------------------------------------
	// both registers read zero: halt bit is write-one, pause is write-any
	always_ff @(posedge core_clk)
	begin
		if (srst)
			rdata_r <= `CHRP_CSR_READ_ZERO;
		else
			rdata_r <= `CHRP_CSR_READ_ZERO;
	end

	// hit only for the two mapped addresses
	always_ff @(posedge core_clk)
	begin
		if (srst)
			hit_r <= 1'b0;
		else
			hit_r <= csr_req.rd_en
				&& (csr_match(csr_req, `CHRP_CSR_PMC_ADDR)
				|| csr_match(csr_req, `CHRP_CSR_PAUSE_ADDR));
	end

	assign csr_rdata = rdata_r;
	assign csr_hit   = hit_r;

endmodule

/* File: chrp_halt_ctrl_sva.sv */
`timescale 1ns/1ps
module chrp_halt_chk
(
	input wire logic                    core_clk,
	input wire logic                    srst,
	input wire chrp_pkg::chrp_csr_req_t csr_req,
	input wire logic [31:0]             csr_rdata,
	input wire logic                    csr_hit,
	input wire logic                    mpc_halt_req,
	input wire logic                    mpc_halt_ack,
	input wire logic                    mpc_run_req,
	input wire logic                    mpc_run_ack,
	input wire logic                    debug_mode_status,
	input wire logic                    pmu_halt_req,
	input wire logic                    pmu_halted,
	input wire chrp_pkg::chrp_wake_t    wake,
	input wire logic                    dbg_halt_req,
	input wire logic                    dma_req,
	input wire logic                    dma_grant,
	input wire logic                    wfi_exec,
	input wire logic                    wfi_retire,
	input wire logic                    core_running
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	halt_ack_a: assert property (mpc_halt_req && debug_mode_status |=> mpc_halt_ack)
		else $error("halt ack missing");
	halt_hold_a: assert property (debug_mode_status && mpc_halt_req |=> debug_mode_status)
		else $error("left debug halt early");
	status_clear_a: assert property (core_running |-> !debug_mode_status)
		else $error("debug status while running");
	run_ack_a: assert property ($rose(mpc_run_ack) |-> core_running && $past(core_running))
		else $error("run ack before running");
	ack_drop_a: assert property (!mpc_run_req |=> !mpc_run_ack)
		else $error("run ack held");
	nmi_wake_a: assert property (pmu_halted && wake.nmi && !pmu_halt_req && !mpc_halt_req
		&& !dbg_halt_req |=> core_running)
		else $error("no wake on nmi");
	csr_zero_a: assert property (csr_req.rd_en && (csr_req.addr == 12'h7C6
		|| csr_req.addr == 12'h7C2) |=> csr_hit && csr_rdata == 32'h0000_0000)
		else $error("csr read not zero");
	dma_serve_a: assert property (dma_req |-> dma_grant)
		else $error("dma not served");
	wfi_nop_a: assert property (wfi_exec |-> wfi_retire)
		else $error("wfi not retired");
endmodule

bind chrp_halt_ctrl chrp_halt_chk u_chk (.core_clk, .srst, .csr_req, .csr_rdata, .csr_hit,
	.mpc_halt_req, .mpc_halt_ack, .mpc_run_req, .mpc_run_ack, .debug_mode_status,
	.pmu_halt_req, .pmu_halted, .wake, .dbg_halt_req, .dma_req, .dma_grant, .wfi_exec,
	.wfi_retire, .core_running);

/* File: chrp_mpc_model.sv */
`timescale 1ns/1ps
module chrp_mpc_model
(
	input wire logic       core_clk,
	input wire logic       srst,
	input wire logic       go,
	input wire logic [3:0] lag,
	input wire logic       mpc_run_ack,
	output logic           mpc_run_req
);
	logic [3:0] wait_r;
	// lag holds the request past the ack, as a slow controller would
	always_ff @(posedge core_clk)
	begin
		if (srst || (mpc_run_req && mpc_run_ack && wait_r == lag))
		begin
			mpc_run_req <= 1'b0;
			wait_r <= 4'h0;
		end
		else if (go)
			mpc_run_req <= 1'b1;
		else if (mpc_run_req && mpc_run_ack)
			wait_r <= wait_r + 4'h1;
	end
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic core_clk, srst, dbg_halt_req, dbg_resume_req, dbg_op_busy, mpc_halt_req, go;
	logic mpc_run_req, mpc_halt_ack, mpc_run_ack, debug_mode_status, pmu_halt_req, int_ok;
	logic pmu_run_req, pmu_halted, ext_int_pending, mstatus_mie, mie_meie, any_int;
	logic wfi_exec, dma_req, dma_grant, exec_stall, wfi_retire, core_running, csr_hit;
	logic                    mpc_reset_run;
	logic [31:0]             csr_rdata;
	logic [3:0]              lag;
	chrp_pkg::chrp_csr_req_t csr_req;
	chrp_pkg::chrp_wake_t    wake;
	int                      n_fail, n_compared, k, n;

	chrp_halt_ctrl dut (.core_clk, .srst, .csr_req, .csr_rdata, .csr_hit, .dbg_halt_req,
		.dbg_resume_req, .dbg_op_busy, .mpc_halt_req, .mpc_halt_ack, .mpc_run_req,
		.mpc_run_ack, .mpc_reset_run, .debug_mode_status, .pmu_halt_req, .pmu_run_req,
		.pmu_halted, .wake, .ext_int_pending, .mstatus_mie, .mie_meie, .any_int,
		.pipe_idle(1'b1), .wfi_exec, .dma_req, .dma_grant, .exec_stall,
		.int_take_ok(int_ok), .wfi_retire, .core_running);
	chrp_mpc_model mpc (.core_clk, .srst, .go, .lag, .mpc_run_ack, .mpc_run_req);

	initial
	begin
		core_clk = 0;
		forever #2.5 core_clk = ~core_clk;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task tick; @(posedge core_clk); #1; endtask
	task automatic pls(ref logic s); s = 1; tick; s = 0; endtask
	task chk(input string nm, input logic [31:0] exp, got);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task csr(input logic w, input logic [11:0] a, input logic [31:0] d);
		csr_req = '{w, !w, a, d};
		tick;
		csr_req = '0;
	endtask
	task wrun; for (n = 0; n < 40 && core_running !== 1'b1; n++) tick; endtask
	task whalt; for (n = 0; n < 40 && pmu_halted !== 1'b1; n++) tick; endtask
	task test_done;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		csr(0, 12'h7C6, 32'h0);
		chk("pmc_hit", 1, csr_hit);
		chk("pmc_rd", 0, csr_rdata);
		csr(1, 12'h7C2, 32'h0000_0003);
		csr(0, 12'h7C2, 32'h0);
		chk("pause_rd", 0, csr_rdata);
		csr(0, 12'h7C0, 32'h0);
		chk("unmapped", 0, csr_hit);
		wfi_exec = 1;
		#1 chk("wfi", 1, wfi_retire & core_running);
		tick;
		wfi_exec = 0;
		repeat (8) tick;
		$display("t_regs done");
	endtask
	task t_pause;
		csr(1, 12'h7C2, 32'h0000_0008);
		for (n = 0; n < 40 && exec_stall === 1'b1; n++)
		begin
			chk("pause_run", 1, core_running);
			tick;
		end
		chk("pause_len", 1, n > 4 && n < 14);
		csr(1, 12'h7C2, 32'h0000_FFFF);
		csr(1, 12'h7C2, 32'h0000_0004);
		for (n = 0; n < 40 && exec_stall === 1'b1; n++) tick;
		chk("reload", 1, n < 9);
		csr(1, 12'h7C2, 32'h0000_FFFF);
		wake.int_timer = 1;
		tick;
		wake.int_timer = 0;
		tick;
		chk("timer_end", 0, exec_stall);
		csr(1, 12'h7C2, 32'h0000_0020);
		pmu_halt_req = 1;
		whalt;
		pmu_halt_req = 0;
		repeat (40) tick;
		pls(pmu_run_req);
		wrun;
		chk("frozen", 1, exec_stall);
		pls(any_int);
		tick;
		chk("int_end", 0, exec_stall);
		$display("t_pause done");
	endtask
	task t_fw;
		for (k = 0; k < 5; k++)
		begin
			csr(1, 12'h7C6, 32'hFFFF_FFFF);
			whalt;
			chk("fw_halt", 1, pmu_halted);
			dma_req = 1;
			tick;
			chk("dma", 1, dma_grant);
			dma_req = 0;
			if (k == 1)
			begin
				ext_int_pending = 1;
				wake.pic_wakeup = 1;
				repeat (3) tick;
				chk("no_enable", 1, pmu_halted);
				wake.pic_wakeup = 0;
				{mstatus_mie, mie_meie} = 2'h3;
				repeat (3) tick;
				chk("low_prio", 1, pmu_halted);
			end
			wake = chrp_pkg::chrp_wake_t'(5'h10 >> k);
			wrun;
			chk("woke", 1, core_running);
			if (k == 1)
				chk("int_ok", 1, int_ok);
			wake = '0;
			{ext_int_pending, mstatus_mie, mie_meie} = 3'h0;
		end
		$display("t_fw done");
	endtask
	task t_dbg1;
		pls(dbg_halt_req);
		mpc_halt_req = 1;
		repeat (2) tick;
		chk("halt_ack", 1, mpc_halt_ack);
		mpc_halt_req = 0;
		dbg_op_busy = 1;
		lag = 4'h3;
		pls(go);
		repeat (4) tick;
		chk("busy_hold", 1, debug_mode_status);
		chk("no_ack", 0, mpc_run_ack);
		dbg_op_busy = 0;
		pls(dbg_resume_req);
		wrun;
		chk("status_off", 0, debug_mode_status);
		for (n = 0; n < 10 && mpc_run_ack !== 1'b1; n++) tick;
		chk("run_ack", 1, mpc_run_ack & core_running);
		repeat (8) tick;
		chk("ack_drop", 0, {mpc_run_req, mpc_run_ack});
		$display("t_dbg1 done");
	endtask
	task t_dbg2;
		mpc_halt_req = 1;
		repeat (3) tick;
		pls(dbg_halt_req);
		mpc_halt_req = 0;
		pls(dbg_resume_req);
		csr(1, 12'h7C6, 32'h0000_0001);
		repeat (3) tick;
		chk("wait_mpc", 1, debug_mode_status);
		lag = 4'h0;
		pls(go);
		wrun;
		repeat (3) tick;
		chk("halt_ign", 0, pmu_halted);
		$display("t_dbg2 done");
	endtask
	task t_strap;
		mpc_reset_run = 0;
		srst = 1;
		repeat (2) tick;
		srst = 0;
		repeat (2) tick;
		pls(dbg_resume_req);
		tick;
		chk("strap_halt", 1, debug_mode_status);
		mpc_reset_run = 1;
		lag = 4'h0;
		pls(go);
		wrun;
		chk("strap_run", 1, core_running);
		$display("t_strap done");
	endtask

	initial
	begin
		{srst, dbg_halt_req, dbg_resume_req, dbg_op_busy, mpc_halt_req, pmu_halt_req} = 6'h20;
		{pmu_run_req, ext_int_pending, mstatus_mie, mie_meie, any_int, wfi_exec} = 6'h00;
		{dma_req, go} = 2'h0;
		csr_req = '0;
		wake = '0;
		lag = 4'h0;
		mpc_reset_run = 1;
		n_fail = 0;
		n_compared = 0;
		repeat (8) @(posedge core_clk);
		#1 srst = 0;
		tick;
		t_regs;
		t_pause;
		t_fw;
		t_dbg1;
		t_dbg2;
		t_strap;
		test_done;
	end
	initial
	begin
		#100000;
		n_fail++;
		test_done;
	end
endmodule
